// [design/line_receive_system_output.sv]
// Overview of operation
// RULE1: Hardware mode single rail always reports violations
// RULE2: Violation flag high one receive clock cycle
// RULE3: Dual rail with recovery outputs retimed NRZ
// RULE4: Dual rail bypass passes raw slicer rails
// RULE5: Data launched on selectable rising/falling edge
// RULE6: Receive data level selectable, normal or inverted
// RULE7: Receive clock 1.544 or 2.048 MHz
// RULE8: Loss with alarm enable uses master clock
// RULE9: Recovery mode outputs recovered line clock
// RULE10: Bypass clock is XOR of slicer rails
// RULE11: System supplies 2.048/1.544 MHz master clock
// RULE12: Master clock times recovery, attenuator, interface
// RULE13: Master clock times test patterns when selected
// RULE14: Auto all-ones and alarm master-timed while master clock not lost
// RULE15: Hardware mode all-ones/PRBS use master clock
// RULE16: Lost master clock tristates transmit driver
// RULE17: Signal-absent flag rises on loss
// RULE18: Signal-absent flag clears itself on recovery
// RULE19: Independent outputs for each of two channels
// RULE20: System samples on edge opposite launch
`timescale 1ns/1ps
module line_receive_system_output #(
    parameter int CHANNELS = 2
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [CHANNELS-1:0] slicer_pos_rail,
    input wire logic [CHANNELS-1:0] slicer_neg_rail,
    input wire logic [CHANNELS-1:0] line_recovered_clock,
    input wire logic [CHANNELS-1:0] loss_detected,
    input wire logic master_clock,
    output logic [CHANNELS-1:0] recovered_line_clock,
    output logic [CHANNELS-1:0] positive_rail_receive_data,
    output logic [CHANNELS-1:0] negative_rail_receive_data,
    output logic [CHANNELS-1:0] signal_absent_flag,
    output logic [CHANNELS-1:0] tx_timing_from_master,
    output logic transmit_line_hiz
);
    import line_rx_pkg::*;

    localparam int SYNC_W = 4 * CHANNELS + 1; // All pins crossing into hclk

    // Synchroniser stages; first stage feeds only the second
    logic [SYNC_W-1:0] sync_meta;
    logic [SYNC_W-1:0] sync_pins;
    logic [CHANNELS-1:0] pos_s, neg_s, lclk_s, los_s;
    logic master_s; // Master clock level in hclk domain [RULE12]

    // Software registers
    logic [15:0] ctrl [CHANNELS]; // Per-channel control
    logic [15:0] next_ctrl [CHANNELS];
    logic hw_mode, next_hw_mode; // Hardware control mode
    logic [7:0] status; // Read-only view of block state

    // Bus data-phase bookkeeping
    logic [7:0] addr_q, next_addr_q;
    logic write_q, next_write_q;
    logic active_q, next_active_q;
    logic [31:0] next_hrdata;
    logic take; // Address phase accepted this cycle

    // Master clock supervision
    logic master_prev, next_master_prev;
    logic [7:0] loss_cnt, next_loss_cnt;
    logic master_lost, next_master_lost;
    logic [CHANNELS-1:0] next_tx_master;
    logic [CHANNELS-1:0] next_absent;

    // Read multiplexer used when a read address phase is taken
    function automatic logic [31:0] read_word(input logic [7:0] a, input logic [15:0] c0,
        input logic [15:0] c1, input logic hw, input logic [7:0] st);
        unique case (a)
            ADDR_CTRL0: return {16'h0000, c0};
            ADDR_CTRL1: return {16'h0000, c1};
            ADDR_GLOBAL: return {31'h00000000, hw};
            ADDR_STATUS: return {24'h000000, st};
            default: return 32'h00000000; // Unmapped reads as zero
        endcase
    endfunction

    // Two-flop synchronisers for every pin from outside hclk
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_meta <= '0;
            sync_pins <= '0;
        end else begin
            sync_meta <= {master_clock, loss_detected, line_recovered_clock,
                slicer_neg_rail, slicer_pos_rail};
            sync_pins <= sync_meta;
        end
    end

    // Split the synchronised vector
    always_comb begin
        pos_s = sync_pins[CHANNELS-1:0];
        neg_s = sync_pins[2*CHANNELS-1:CHANNELS];
        lclk_s = sync_pins[3*CHANNELS-1:2*CHANNELS];
        los_s = sync_pins[4*CHANNELS-1:3*CHANNELS];
        master_s = sync_pins[SYNC_W-1];
    end

    // Bus address phase capture and register writes
    always_comb begin
        take = hsel & htrans[1] & hready;
        next_active_q = take;
        next_addr_q = take ? haddr[7:0] : addr_q;
        next_write_q = take ? hwrite : write_q;
        next_ctrl = ctrl;
        next_hw_mode = hw_mode;
        // Write data arrives in the data phase; hsize is ignored, so writes of any size update the field
        if (active_q && write_q) begin
            unique case (addr_q)
                ADDR_CTRL0: next_ctrl[0] = hwdata[15:0];
                ADDR_CTRL1: next_ctrl[1] = hwdata[15:0];
                ADDR_GLOBAL: next_hw_mode = hwdata[F_HW_MODE];
                default: next_hw_mode = hw_mode; // Status and holes ignore writes
            endcase
        end
        // Read data built from next values so a write just before is seen
        next_hrdata = hrdata;
        if (take && !hwrite) begin
            next_hrdata = read_word(haddr[7:0], next_ctrl[0], next_ctrl[1],
                next_hw_mode, status);
        end
    end

    // Register the bus side
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            active_q <= 1'b0;
            addr_q <= 8'h00;
            write_q <= 1'b0;
            hrdata <= 32'h00000000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
            hw_mode <= GLOBAL_RESET;
            for (int i = 0; i < CHANNELS; i++) begin
                ctrl[i] <= CTRL_RESET;
            end
        end else begin
            active_q <= next_active_q;
            addr_q <= next_addr_q;
            write_q <= next_write_q;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1; // Zero wait states
            hresp <= 1'b0; // Always OKAY
            hw_mode <= next_hw_mode;
            ctrl <= next_ctrl;
        end
    end

    // Master clock loss watch and transmit timing choice
    always_comb begin
        next_master_prev = master_s;
        next_loss_cnt = loss_cnt;
        next_master_lost = master_lost;
        if (master_s != master_prev) begin
            next_loss_cnt = 8'h00;
            next_master_lost = 1'b0;
        end else if (loss_cnt == MASTER_LOSS_CYC - 8'h01) begin
            next_master_lost = 1'b1; // [RULE16]
        end else begin
            next_loss_cnt = loss_cnt + 8'h01;
        end
        for (int i = 0; i < CHANNELS; i++) begin
            // Automatic all-ones and alarm pattern use the master whenever it is not lost
            next_tx_master[i] = ~master_lost & (
                (ctrl[i][F_AUTO_ALL_ONES] & los_s[i]) | ctrl[i][F_ALARM_SEND] // [RULE14]
                | ((ctrl[i][F_ALL_ONES_SEND] | ctrl[i][F_PRBS_SEND])
                & (ctrl[i][F_TX_REF_MASTER] | hw_mode))); // [RULE13] [RULE15]
            next_absent[i] = los_s[i]; // Follows loss both ways [RULE17] [RULE18]
        end
    end

    // Status assembled from flops only
    always_comb begin
        status = 8'h00;
        status[S_LOS_LO +: 2] = signal_absent_flag[1:0];
        status[S_MASTER_LOST] = master_lost;
        status[S_TX_HIZ] = transmit_line_hiz;
        status[S_TX_MASTER_LO +: 2] = tx_timing_from_master[1:0];
    end

    // Register supervision state and its outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            master_prev <= 1'b0;
            loss_cnt <= 8'h00;
            master_lost <= 1'b0;
            transmit_line_hiz <= 1'b0;
            tx_timing_from_master <= '0;
            signal_absent_flag <= '0;
        end else begin
            master_prev <= next_master_prev;
            loss_cnt <= next_loss_cnt;
            master_lost <= next_master_lost;
            transmit_line_hiz <= next_master_lost; // [RULE16]
            tx_timing_from_master <= next_tx_master;
            signal_absent_flag <= next_absent; // [RULE17] [RULE18]
        end
    end

    // One independent path per channel; outputs come from its flops
    for (genvar g = 0; g < CHANNELS; g++) begin : g_chan
        rx_channel_path u_path ( // [RULE19]
            .hclk(hclk),
            .hresetn(hresetn),
            .pos_rail(pos_s[g]),
            .neg_rail(neg_s[g]),
            .line_clk(lclk_s[g]),
            .master_clk(master_s), // [RULE12]
            .signal_absent(los_s[g]),
            .ctrl(ctrl[g]),
            .hw_mode(hw_mode),
            .recovered_line_clock(recovered_line_clock[g]),
            .positive_rail_receive_data(positive_rail_receive_data[g]),
            .negative_rail_receive_data(negative_rail_receive_data[g])
        );
    end
endmodule

// [design/rx_channel_path.sv]
`timescale 1ns/1ps
module rx_channel_path (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic pos_rail,
    input wire logic neg_rail,
    input wire logic line_clk,
    input wire logic master_clk,
    input wire logic signal_absent,
    input wire logic [15:0] ctrl,
    input wire logic hw_mode,
    output logic recovered_line_clock,
    output logic positive_rail_receive_data,
    output logic negative_rail_receive_data
);
    import line_rx_pkg::*;

    // Excess-zero limit for the current line standard and coding
    function automatic logic [4:0] exz_limit(input logic e1, input logic coded);
        if (e1) begin
            return EXZ_E1;
        end
        return coded ? EXZ_T1_CODED : EXZ_T1_AMI;
    endfunction

    clk_src_t src; // Chosen receive clock source
    logic sel_clk; // Level of the chosen clock
    logic launch; // Active edge seen this cycle
    logic clk_prev, next_clk_prev;
    logic next_rclk, next_dpos, next_dneg;
    logic last_pos, next_last_pos; // Polarity of the last mark
    logic seen_mark, next_seen_mark;
    logic [4:0] zero_cnt, next_zero_cnt; // Zeros since the last mark
    logic mark, bpv, legal_sub, excess_zero_error;

    // Clock source: master under alarm-enabled loss, else line or rails
    always_comb begin
        if (signal_absent && ctrl[F_ALARM_PATTERN_EN]) begin
            src = SRC_MASTER; // [RULE8]
        end else if (ctrl[F_CDR_EN]) begin
            src = SRC_LINE; // [RULE9]
        end else begin
            src = SRC_RAILS; // [RULE10]
        end
        unique case (src)
            SRC_LINE: sel_clk = line_clk;
            SRC_RAILS: sel_clk = pos_rail ^ neg_rail; // [RULE10]
            default: sel_clk = master_clk; // Only SRC_MASTER reaches here
        endcase
    end

    // Launch edge and data path next values
    always_comb begin
        launch = ctrl[F_EDGE_FALLING] ? (clk_prev & ~sel_clk) : (~clk_prev & sel_clk); // [RULE5]
        next_clk_prev = sel_clk;
        next_rclk = sel_clk; // Rate follows the source [RULE7]
        next_dpos = positive_rail_receive_data;
        next_dneg = negative_rail_receive_data;
        next_last_pos = last_pos;
        next_seen_mark = seen_mark;
        next_zero_cnt = zero_cnt;
        mark = pos_rail | neg_rail;
        bpv = (pos_rail & neg_rail) | (seen_mark & ((pos_rail & last_pos) | (neg_rail & ~last_pos)));
        // A violation after enough zeros is taken as a substitution code
        legal_sub = ctrl[F_DECODER_EN] & bpv & ~(pos_rail & neg_rail)
            & (zero_cnt >= (ctrl[F_E1_MODE] ? SUB_ZEROS_E1 : SUB_ZEROS_T1));
        excess_zero_error = (hw_mode | ctrl[F_EXZ_REPORT]) & ~mark
            & (zero_cnt == exz_limit(ctrl[F_E1_MODE], ctrl[F_DECODER_EN]) - 5'h01); // [RULE1]
        if (!ctrl[F_SINGLE_RAIL] && !ctrl[F_CDR_EN]) begin
            // Raw slicer rails, no retiming
            next_dpos = pos_rail ^ ctrl[F_DATA_INVERT]; // [RULE4] [RULE6]
            next_dneg = neg_rail ^ ctrl[F_DATA_INVERT]; // [RULE4] [RULE6]
        end else if (launch) begin
            if (ctrl[F_SINGLE_RAIL]) begin
                // Decoded data; flag held until the next launch edge
                next_dpos = (mark & ~legal_sub) ^ ctrl[F_DATA_INVERT]; // [RULE6]
                next_dneg = (bpv & ~legal_sub) | excess_zero_error; // [RULE1] [RULE2]
                next_zero_cnt = mark ? 5'h00 : (zero_cnt == 5'h1F ? zero_cnt : zero_cnt + 5'h01);
                if (mark && !(pos_rail && neg_rail)) begin
                    next_last_pos = pos_rail;
                    next_seen_mark = 1'b1;
                end
            end else begin
                // Retimed NRZ rails
                next_dpos = pos_rail ^ ctrl[F_DATA_INVERT]; // [RULE3] [RULE6]
                next_dneg = neg_rail ^ ctrl[F_DATA_INVERT]; // [RULE3] [RULE6]
            end
        end
    end

    // Register the channel state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_prev <= 1'b0;
            recovered_line_clock <= 1'b0;
            positive_rail_receive_data <= 1'b0;
            negative_rail_receive_data <= 1'b0;
            last_pos <= 1'b0;
            seen_mark <= 1'b0;
            zero_cnt <= 5'h00;
        end else begin
            clk_prev <= next_clk_prev;
            recovered_line_clock <= next_rclk;
            positive_rail_receive_data <= next_dpos;
            negative_rail_receive_data <= next_dneg;
            last_pos <= next_last_pos;
            seen_mark <= next_seen_mark;
            zero_cnt <= next_zero_cnt;
        end
    end
endmodule

// [inc/line_rx_pkg.sv]
package line_rx_pkg;
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL0 = 8'h00;
    localparam logic [7:0] ADDR_CTRL1 = 8'h04;
    localparam logic [7:0] ADDR_GLOBAL = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;
    // Channel control field positions
    localparam int F_SINGLE_RAIL = 0;
    localparam int F_CDR_EN = 1;
    localparam int F_DECODER_EN = 2;
    localparam int F_EDGE_FALLING = 3;
    localparam int F_DATA_INVERT = 4;
    localparam int F_E1_MODE = 5;
    localparam int F_ALARM_PATTERN_EN = 6;
    localparam int F_EXZ_REPORT = 7;
    localparam int F_TX_REF_MASTER = 8;
    localparam int F_ALL_ONES_SEND = 9;
    localparam int F_PRBS_SEND = 10;
    localparam int F_AUTO_ALL_ONES = 11;
    localparam int F_ALARM_SEND = 12;
    // Global and status field positions
    localparam int F_HW_MODE = 0;
    localparam int S_LOS_LO = 0;
    localparam int S_MASTER_LOST = 2;
    localparam int S_TX_HIZ = 3;
    localparam int S_TX_MASTER_LO = 4;
    // Reset values
    localparam logic [15:0] CTRL_RESET = 16'h0002;
    localparam logic [0:0] GLOBAL_RESET = 1'h0;
    // Timing: master clock declared lost after this long without an edge
    localparam int CLK_FREQ_MHZ = 40;
    localparam int MASTER_LOSS_NS = 2000;
    localparam logic [7:0] MASTER_LOSS_CYC = 8'((MASTER_LOSS_NS * CLK_FREQ_MHZ + 999) / 1000);
    // Excess-zero limits and zeros that may precede a legal substitution
    localparam logic [4:0] EXZ_T1_AMI = 5'h10;
    localparam logic [4:0] EXZ_T1_CODED = 5'h08;
    localparam logic [4:0] EXZ_E1 = 5'h04;
    localparam logic [4:0] SUB_ZEROS_T1 = 5'h03;
    localparam logic [4:0] SUB_ZEROS_E1 = 5'h02;
    // Source of the receive clock
    typedef enum logic [1:0] {
        SRC_LINE = 2'b00,
        SRC_RAILS = 2'b01,
        SRC_MASTER = 2'b10
    } clk_src_t;
endpackage

// [sim/line_receive_system_output_bench.sv]
`timescale 1ns/1ps
module line_receive_system_output_bench;
    import line_rx_pkg::*;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] pos = 2'b00;
    logic [1:0] neg = 2'b00;
    logic [1:0] lclk = 2'b00;
    logic [1:0] loss = 2'b00;
    logic [1:0] falling = 2'b00;
    logic run_master = 1'b1;
    logic hready, hreadyout, hresp, mclk, hiz;
    logic [31:0] hrdata, rd;
    logic [1:0] rclk, dp, dn, absent, txm, gp, gn;
    int err_count = 0;
    int checks_done = 0;
    assign hready = hreadyout; // Single slave
    always #12.5 hclk = ~hclk;
    line_receive_system_output #(.CHANNELS(2)) line_receive_system_output_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .slicer_pos_rail(pos), .slicer_neg_rail(neg), .line_recovered_clock(lclk),
        .loss_detected(loss), .master_clock(mclk), .recovered_line_clock(rclk),
        .positive_rail_receive_data(dp), .negative_rail_receive_data(dn),
        .signal_absent_flag(absent), .tx_timing_from_master(txm), .transmit_line_hiz(hiz)
    );
    rx_framer_model rx_framer_model_i (
        .run_master(run_master), .edge_falling(falling), .rx_clock(rclk), .rx_pos(dp),
        .rx_neg(dn), .master_clock(mclk), .got_pos(gp), .got_neg(gn)
    );
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tick(input int c);
        repeat (c) @(posedge hclk);
    endtask
    // Bounded wait for the slave; a hang ends the run
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            $display("mismatch hreadyout expected 1 seen %b", hreadyout);
            err_count++;
            stop_test();
        end
    endtask
    // One AHB single word transfer; read data lands in rd
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr <= {24'h0, a};
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
    endtask
    // 200 ns line bits; e[i] is what the framer holds as bit i starts
    task automatic seq(input int ch, input int skip, input logic [1:0] r[$],
            input logic [1:0] e[$]);
        for (int i = 0; i < r.size(); i++) begin
            pos[ch] <= r[i][1];
            neg[ch] <= r[i][0];
            tick(2);
            if (i >= skip) begin
                check("captured rails", e[i], {gp[ch], gn[ch]});
            end
            lclk[ch] <= 1'b1;
            tick(4);
            lclk[ch] <= 1'b0;
            tick(2);
        end
    endtask
    initial begin
        int n;
        logic last;
        logic [1:0] r[$];
        logic [1:0] e[$];
        n = 0;
        last = 1'b0;
        tick(3);
        hresetn <= 1'b1;
        tick(1);
        bus(0, ADDR_CTRL0, 0);
        check("ctrl0", 32'(CTRL_RESET), rd);
        bus(0, ADDR_CTRL1, 0);
        check("ctrl1", 32'(CTRL_RESET), rd);
        bus(0, ADDR_GLOBAL, 0);
        check("global", 32'(GLOBAL_RESET), rd);
        bus(1, ADDR_STATUS, 32'hFFFF_FFFF);
        bus(0, ADDR_STATUS, 0);
        check("status", 0, rd);
        bus(0, 8'h40, 0);
        check("unmapped", 0, rd);
        check("hresp", 0, hresp);
        $display("test registers done");
        r = '{2'b10, 2'b01, 2'b00, 2'b00};
        e = '{2'b00, 2'b10, 2'b01, 2'b00};
        seq(0, 1, r, e);
        $display("test dual rail done");
        // Single rail, hardware mode, E1 zero limit
        bus(1, ADDR_GLOBAL, 1);
        bus(1, ADDR_CTRL0, 32'h0000_0023);
        r = '{2'b10, 2'b01, 2'b01, 2'b11, 2'b00, 2'b00, 2'b00, 2'b00, 2'b00};
        e = '{2'b00, 2'b10, 2'b10, 2'b11, 2'b11, 2'b00, 2'b00, 2'b00, 2'b01};
        seq(0, 1, r, e);
        // T1 with decoder: a violation after 3 zeros is a substitution, not flagged
        bus(1, ADDR_CTRL0, 32'h0000_0007);
        r = '{2'b10, 2'b00, 2'b00, 2'b00, 2'b10, 2'b00, 2'b10, 2'b00};
        e = '{2'b00, 2'b10, 2'b00, 2'b00, 2'b00, 2'b00, 2'b00, 2'b11};
        seq(0, 1, r, e);
        $display("test single rail done");
        bus(1, ADDR_CTRL1, 0);
        for (int i = 0; i < 4; i++) begin
            pos[1] <= i[1];
            neg[1] <= i[0];
            tick(6);
            check("bypass clock", i[1] ^ i[0], rclk[1]);
            check("bypass rails", i[1:0], {dp[1], dn[1]});
        end
        pos[1] <= 1'b0;
        neg[1] <= 1'b0;
        bus(1, ADDR_CTRL1, 32'h0000_001A);
        falling <= 2'b10;
        r = '{2'b10, 2'b01, 2'b00, 2'b00};
        e = '{2'b00, 2'b00, 2'b01, 2'b10};
        seq(1, 2, r, e);
        $display("test edge and level done");
        loss <= 2'b01;
        tick(6);
        check("absent", 2'b01, absent);
        bus(0, ADDR_STATUS, 0);
        check("status loss", 1, rd[1:0]);
        loss <= 2'b00;
        tick(6);
        check("absent clear", 0, absent);
        // Line idle: receive clock must come from the master
        bus(1, ADDR_CTRL1, 32'h0000_0842);
        loss <= 2'b10;
        // Let the source switch settle so the window holds master edges only
        tick(6);
        last = rclk[1];
        for (int k = 0; k < 200; k++) begin
            tick(1);
            n += (rclk[1] !== last);
            last = rclk[1];
        end
        check("master clock edges", 1, n >= 14 && n <= 16);
        check("auto all ones", 2'b10, txm);
        loss <= 2'b00;
        bus(1, ADDR_GLOBAL, 0);
        bus(1, ADDR_CTRL1, 32'h0000_0402);
        tick(4);
        check("prbs local", 0, txm);
        bus(1, ADDR_CTRL1, 32'h0000_0502);
        tick(4);
        check("prbs master", 2'b10, txm);
        bus(1, ADDR_GLOBAL, 1);
        bus(1, ADDR_CTRL1, 32'h0000_0402);
        tick(4);
        check("prbs hardware", 2'b10, txm);
        $display("test timing sources done");
        run_master <= 1'b0;
        tick(120);
        check("driver off", 1, hiz);
        check("timing gated", 0, txm);
        bus(0, ADDR_STATUS, 0);
        check("status lost", 2'b11, rd[3:2]);
        run_master <= 1'b1;
        tick(40);
        check("driver on", 0, hiz);
        $display("test master loss done");
        stop_test();
    end
endmodule

// [sim/line_rx_monitor.sv]
`timescale 1ns/1ps
module line_rx_monitor #(
    parameter int CHANNELS = 2
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic [CHANNELS-1:0] loss_detected,
    input wire logic master_clock,
    input wire logic [CHANNELS-1:0] recovered_line_clock,
    input wire logic [CHANNELS-1:0] positive_rail_receive_data,
    input wire logic [CHANNELS-1:0] negative_rail_receive_data,
    input wire logic [CHANNELS-1:0] signal_absent_flag,
    input wire logic transmit_line_hiz
);
    logic [7:0] quiet; // Cycles since master pin moved
    logic [7:0] next_quiet;
    logic last_mclk; // Master level one cycle ago
    // Saturating count so a long stop never wraps back to zero
    always_comb begin
        next_quiet = (master_clock != last_mclk) ? 8'h00 : quiet + {7'h00, quiet != 8'hFF};
    end
    // Registers only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            quiet <= 8'h00;
            last_mclk <= 1'b0;
        end else begin
            quiet <= next_quiet;
            last_mclk <= master_clock;
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Level held long enough to clear the synchronisers
    sequence s_held(x);
        x [*5];
    endsequence
    property p_absent_set;
        s_held(loss_detected[0]) |-> signal_absent_flag[0];
    endproperty
    a_absent_set: assert property (p_absent_set) else $error("absent flag not raised");
    property p_absent_apart;
        s_held(loss_detected == 2'b10) |-> signal_absent_flag == 2'b10;
    endproperty
    a_absent_apart: assert property (p_absent_apart) else $error("channels not apart");
    property p_absent_clear;
        s_held(loss_detected == 2'b00) |-> signal_absent_flag == 2'b00;
    endproperty
    a_absent_clear: assert property (p_absent_clear) else $error("absent flag stuck");
    property p_hiz_set;
        quiet >= 8'h5A |-> transmit_line_hiz;
    endproperty
    a_hiz_set: assert property (p_hiz_set) else $error("driver not released");
    property p_hiz_clear;
        quiet inside {[8'h06:8'h46]} |-> !transmit_line_hiz;
    endproperty
    a_hiz_clear: assert property (p_hiz_clear) else $error("driver off with clock");
    // Data of channel 0 only moves with its receive clock
    property p_launch;
        $changed({positive_rail_receive_data[0], negative_rail_receive_data[0]})
            |-> $changed(recovered_line_clock[0]);
    endproperty
    a_launch: assert property (p_launch) else $error("data moved off clock edge");
    property p_viol_hold;
        $rose(negative_rail_receive_data[0]) |-> negative_rail_receive_data[0] [*3];
    endproperty
    a_viol_hold: assert property (p_viol_hold) else $error("violation pulse too short");
    property p_ready;
        $past(hresetn) |-> hreadyout;
    endproperty
    a_ready: assert property (p_ready) else $error("bus stalled");
endmodule
bind line_receive_system_output line_rx_monitor #(.CHANNELS(CHANNELS)) line_rx_monitor_i (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .loss_detected(loss_detected),
    .master_clock(master_clock), .recovered_line_clock(recovered_line_clock),
    .positive_rail_receive_data(positive_rail_receive_data),
    .negative_rail_receive_data(negative_rail_receive_data),
    .signal_absent_flag(signal_absent_flag), .transmit_line_hiz(transmit_line_hiz)
);

// [sim/rx_framer_model.sv]
`timescale 1ns/1ps
module rx_framer_model #(
    parameter real HALF_NS = 323.834
) (
    input wire logic run_master,
    input wire logic [1:0] edge_falling,
    input wire logic [1:0] rx_clock,
    input wire logic [1:0] rx_pos,
    input wire logic [1:0] rx_neg,
    output logic master_clock,
    output logic [1:0] got_pos,
    output logic [1:0] got_neg
);
    // Reference at 1.544 MHz; holds its level while stopped
    initial begin
        master_clock = 1'b0;
        forever begin
            #(HALF_NS);
            if (run_master) begin
                master_clock = ~master_clock;
            end
        end
    end
    // Capture on the edge opposite launch, when data is settled
    for (genvar g = 0; g < 2; g++) begin : g_ch
        always @(rx_clock[g]) begin
            if (rx_clock[g] === edge_falling[g]) begin
                got_pos[g] <= rx_pos[g];
                got_neg[g] <= rx_neg[g];
            end
        end
    end
endmodule
